// ===== shared/pmrt_pkg.sv
// Package with register map, field positions and codes of the header signalling and roll-off tracker.
package pmrt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int KEY_W  = 7;
    localparam int KEYS   = 128;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SUB_SLICE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_THR_SMALL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_THR_WIDE  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_VL_LEN1   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_VL_LEN2   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SMALL_CNT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_WIDE_CNT  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h28;

    // Control register fields.
    localparam int CTRL_TS_MODE_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;

    // Interrupt status fields.
    localparam int IRQ_W            = 3;
    localparam int IRQ_DECIDE_BIT   = 0;
    localparam int IRQ_VL_SKIP_BIT  = 1;
    localparam int IRQ_VL_SYNC_BIT  = 2;

    // Reset values and counter limits.
    localparam logic [CNT_W-1:0] THR_SMALL_RST = 16'h0010;
    localparam logic [CNT_W-1:0] THR_WIDE_RST  = 16'h0010;
    localparam logic [CNT_W-1:0] VL_LEN1_RST   = 16'h0000;
    localparam logic [CNT_W-1:0] VL_LEN2_RST   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX       = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ONE       = 16'h0001;

    // Signalling values and fields.
    localparam logic [7:0] CODE_VL_SET1  = 8'h81;
    localparam logic [7:0] CODE_VL_SET2  = 8'h83;
    localparam int         CODE_EXT_BIT  = 7;
    localparam int         CODE_SIZE_BIT = 1;
    localparam logic [1:0] ROLLOFF_LOW   = 2'b11;

    typedef enum logic [1:0] {PREV_U, PREV_0, PREV_1} pmrt_prev_e;
    typedef enum logic [1:0] {RO_NONE, RO_SMALL, RO_WIDE} pmrt_range_e;

endpackage

// ===== design/pmrt_hdr_class.sv
// Classifier of the 8-bit header signalling value into frame classes and tracking key.
`timescale 1ns/10ps
module pmrt_hdr_class
    import pmrt_pkg::*;
(
    input  wire logic [7:0]       code,
    output logic                  extended,
    output logic                  vl_skip,
    output logic                  vl_set2,
    output logic                  short_frame,
    output logic [KEY_W-1:0]      key
);
    assign extended = code[CODE_EXT_BIT];

    assign vl_skip = (code == CODE_VL_SET1) || (code == CODE_VL_SET2);
    assign vl_set2 = (code == CODE_VL_SET2);

    assign short_frame = ~code[CODE_EXT_BIT] & code[CODE_SIZE_BIT];

    assign key = code[CODE_EXT_BIT] ? {1'b1, code[6:1]} : {2'b00, code[6:2]};

endmodule

// ===== design/pmrt_tracker.sv
// Header signalling classifier and per-key roll-off alternation tracker with APB registers.
`timescale 1ns/10ps
// Overview of operation
// - Values 0-127 legacy, 128-255 extended.
// - Extended code keeps legacy codewords unchanged.
// - Legacy header codeword passes without rotation.
// - Extended header: undo quarter-turn phase step.
// - Extended: size bit is enumeration, not length.
// - Values 129/131: skip very-low-SNR frame length.
// - Very-low-SNR frames found only by sync header.
// - Locked: first roll-off 11 selects small range.
// - Key from b2-b6 or b1-b6; slice from header.
// - Two-bit previous state per key, reset uninitialised.
// - Decode all frames, or subscribed slice only.
// - Update previous state per started frame outcome.
// - Roll-off tracking ignores configured input stream.
// - Evidence counters against thresholds decide range.
module pmrt_tracker
    import pmrt_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [pmrt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pmrt_pkg::DATA_W-1:0] pwdata,
    output logic [pmrt_pkg::DATA_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     locked,
    input  wire logic                     acq_start,
    input  wire logic                     hdr_valid,
    input  wire logic [7:0]               hdr_code,
    input  wire logic [7:0]               time_slice_number,
    input  wire logic                     frame_done,
    input  wire logic                     frame_fail,
    input  wire logic                     frame_crc_err,
    input  wire logic [1:0]               frame_rolloff,
    input  wire logic                     vl_sync_det,
    input  wire logic [3:0]               vl_sync_modcod,
    output logic                          hdr_start,
    output logic                          hdr_extended,
    output logic                          hdr_derotate,
    output logic                          hdr_short,
    output logic                          skip_pulse,
    output logic [pmrt_pkg::CNT_W-1:0]    skip_len,
    output logic                          ro_small,
    output logic                          irq
);
    import pmrt_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Register state.
    logic                 ts_mode;
    logic [7:0]           sub_slice;
    logic [CNT_W-1:0]     thr_small;
    logic [CNT_W-1:0]     thr_wide;
    logic [CNT_W-1:0]     vl_len1;
    logic [CNT_W-1:0]     vl_len2;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [3:0]           vl_modcod;

    // Tracking state.
    pmrt_prev_e           prev_tab [KEYS];
    pmrt_range_e          range;
    pmrt_range_e          next_range;
    logic [CNT_W-1:0]     small_rolloff_evidence_count;
    logic [CNT_W-1:0]     wide_rolloff_evidence_count;
    logic [KEY_W-1:0]     cur_key;
    logic                 cur_track;

    // Bus decode.
    wire                  setup_phase = psel & ~penable;
    wire                  wr_take     = psel & penable & pwrite & pready;
    wire                  rd_take     = psel & penable & ~pwrite & pready;
    wire                  addr_ok     = hit(paddr, OFF_CTRL) || hit(paddr, OFF_SUB_SLICE)
                                     || hit(paddr, OFF_THR_SMALL) || hit(paddr, OFF_THR_WIDE)
                                     || hit(paddr, OFF_VL_LEN1) || hit(paddr, OFF_VL_LEN2)
                                     || hit(paddr, OFF_STATUS) || hit(paddr, OFF_SMALL_CNT)
                                     || hit(paddr, OFF_WIDE_CNT) || hit(paddr, OFF_IRQ_STAT)
                                     || hit(paddr, OFF_IRQ_MASK);
    wire                  sw_restart  = wr_take & hit(paddr, OFF_CTRL) & pwdata[CTRL_RESTART_BIT];
    wire                  restart     = acq_start | sw_restart;
    wire                  irq_rd_clr  = rd_take & hit(paddr, OFF_IRQ_STAT);

    // Header classification.
    logic                 cls_ext;
    logic                 cls_vl_skip;
    logic                 cls_vl_set2;
    logic                 cls_short;
    logic [KEY_W-1:0]     cls_key;

    pmrt_hdr_class u_class
    (
        .code        (hdr_code),
        .extended    (cls_ext),
        .vl_skip     (cls_vl_skip),
        .vl_set2     (cls_vl_set2),
        .short_frame (cls_short),
        .key         (cls_key)
    );

    wire                  slice_ok    = ~ts_mode | (time_slice_number == sub_slice);
    wire                  start_dec   = hdr_valid & ~cls_vl_skip & slice_ok;

    wire                  upd         = frame_done & cur_track & ~restart;
    wire                  cls_u       = frame_fail | frame_crc_err;
    wire                  cls_low     = ~cls_u & (frame_rolloff == ROLLOFF_LOW);
    wire                  cls_high    = ~cls_u & (frame_rolloff != ROLLOFF_LOW);
    wire pmrt_prev_e      prev_cur    = prev_tab[cur_key];

    wire                  ev_small    = upd & ((cls_low & (prev_cur == PREV_0))
                                        | (cls_high & (prev_cur == PREV_1)));
    wire                  ev_wide     = upd & ((cls_low & (prev_cur == PREV_1))
                                        | (cls_high & (prev_cur == PREV_0)));
    wire pmrt_prev_e      prev_new    = cls_u ? PREV_U : (cls_low ? PREV_1 : PREV_0);

    wire [CNT_W-1:0]      next_small  = (small_rolloff_evidence_count == CNT_MAX)
                                        ? CNT_MAX : small_rolloff_evidence_count + CNT_ONE;
    wire [CNT_W-1:0]      next_wide   = (wide_rolloff_evidence_count == CNT_MAX)
                                        ? CNT_MAX : wide_rolloff_evidence_count + CNT_ONE;

    wire                  small_over  = small_rolloff_evidence_count >= thr_small;
    wire                  wide_over   = wide_rolloff_evidence_count >= thr_wide;

    wire                  first_low   = upd & cls_low & locked;

    always_comb
    begin
        next_range = range;
        case (range)
            RO_NONE:
            begin
                if (first_low || small_over)
                    next_range = RO_SMALL;
                else if (wide_over)
                    next_range = RO_WIDE;
            end
            RO_SMALL:
            begin
                if (wide_over && !small_over && !first_low)
                    next_range = RO_WIDE;
            end
            RO_WIDE:
            begin
                if (first_low || small_over)
                    next_range = RO_SMALL;
            end
            default:
            begin
                next_range = RO_NONE;
            end
        endcase
    end

    wire                  decide_evt  = (next_range != range) & ~restart;

    // Read data selection.
    wire [DATA_W-1:0]     rd_val =
        hit(paddr, OFF_CTRL)      ? {31'h0, ts_mode} :
        hit(paddr, OFF_SUB_SLICE) ? {24'h0, sub_slice} :
        hit(paddr, OFF_THR_SMALL) ? {16'h0, thr_small} :
        hit(paddr, OFF_THR_WIDE)  ? {16'h0, thr_wide} :
        hit(paddr, OFF_VL_LEN1)   ? {16'h0, vl_len1} :
        hit(paddr, OFF_VL_LEN2)   ? {16'h0, vl_len2} :
        hit(paddr, OFF_STATUS)    ? {24'h0, vl_modcod, locked, cur_track, range} :
        hit(paddr, OFF_SMALL_CNT) ? {16'h0, small_rolloff_evidence_count} :
        hit(paddr, OFF_WIDE_CNT)  ? {16'h0, wide_rolloff_evidence_count} :
        hit(paddr, OFF_IRQ_STAT)  ? {29'h0, irq_stat} :
        hit(paddr, OFF_IRQ_MASK)  ? {29'h0, irq_mask} : 32'h0;

    // Interrupt events; a read clears only the bits it returned, and a new event wins.
    wire [IRQ_W-1:0]      irq_evt = {vl_sync_det, hdr_valid & cls_vl_skip, decide_evt};
    wire [IRQ_W-1:0]      next_irq_stat = (irq_stat & ~(irq_rd_clr ? prdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_evt;

    // APB answer: one wait-free access phase, data latched at setup.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_ok;
            prdata  <= (setup_phase & ~pwrite) ? rd_val : 32'h0;
        end
    end

    // Software-written configuration.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ts_mode   <= 1'b0;
            sub_slice <= 8'h00;
            thr_small <= THR_SMALL_RST;
            thr_wide  <= THR_WIDE_RST;
            vl_len1   <= VL_LEN1_RST;
            vl_len2   <= VL_LEN2_RST;
            irq_mask  <= {IRQ_W{1'b0}};
        end
        else if (wr_take)
        begin
            if (hit(paddr, OFF_CTRL))
                ts_mode <= pwdata[CTRL_TS_MODE_BIT];
            else if (hit(paddr, OFF_SUB_SLICE))
                sub_slice <= pwdata[7:0];
            else if (hit(paddr, OFF_THR_SMALL))
                thr_small <= pwdata[CNT_W-1:0];
            else if (hit(paddr, OFF_THR_WIDE))
                thr_wide <= pwdata[CNT_W-1:0];
            else if (hit(paddr, OFF_VL_LEN1))
                vl_len1 <= pwdata[CNT_W-1:0];
            else if (hit(paddr, OFF_VL_LEN2))
                vl_len2 <= pwdata[CNT_W-1:0];
            else if (hit(paddr, OFF_IRQ_MASK))
                irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    // Interrupt status and line.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat <= {IRQ_W{1'b0}};
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    // Header-side outputs, one cycle after the header strobe.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hdr_start    <= 1'b0;
            hdr_extended <= 1'b0;
            hdr_derotate <= 1'b0;
            hdr_short    <= 1'b0;
            skip_pulse   <= 1'b0;
            skip_len     <= {CNT_W{1'b0}};
        end
        else
        begin
            hdr_start <= start_dec;
            if (hdr_valid)
            begin
                hdr_extended <= cls_ext;
                hdr_derotate <= cls_ext;
                hdr_short    <= cls_short;
            end
            skip_pulse <= hdr_valid & cls_vl_skip;
            if (hdr_valid && cls_vl_skip)
                skip_len <= cls_vl_set2 ? vl_len2 : vl_len1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vl_modcod <= 4'h0;
        else if (vl_sync_det)
            vl_modcod <= vl_sync_modcod;
    end

    // Frame context, stream id not used
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_key   <= {KEY_W{1'b0}};
            cur_track <= 1'b0;
        end
        else if (restart)
            cur_track <= 1'b0;
        else if (start_dec)
        begin
            cur_key   <= cls_key;
            cur_track <= 1'b1;
        end
        else if (frame_done)
            cur_track <= 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < KEYS; gi++)
        begin : g_prev
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    prev_tab[gi] <= PREV_U;
                else if (restart)
                    prev_tab[gi] <= PREV_U;
                else if (upd && (cur_key == KEY_W'(gi)))
                    prev_tab[gi] <= prev_new;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            small_rolloff_evidence_count <= {CNT_W{1'b0}};
            wide_rolloff_evidence_count  <= {CNT_W{1'b0}};
            range                        <= RO_NONE;
            ro_small                     <= 1'b0;
        end
        else if (restart)
        begin
            small_rolloff_evidence_count <= {CNT_W{1'b0}};
            wide_rolloff_evidence_count  <= {CNT_W{1'b0}};
            range                        <= RO_NONE;
            ro_small                     <= 1'b0;
        end
        else
        begin
            if (ev_small)
                small_rolloff_evidence_count <= next_small;
            if (ev_wide)
                wide_rolloff_evidence_count <= next_wide;
            range    <= next_range;
            ro_small <= (next_range == RO_SMALL);
        end
    end

endmodule

// ===== dv/pmrt_tracker_checker.sv
// Concurrent checks of the tracker's bus, header class and roll-off outputs.
`timescale 1ns/10ps
module pmrt_tracker_checker
    import pmrt_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       locked,
    input wire logic       hdr_valid,
    input wire logic [7:0] hdr_code,
    input wire logic       frame_done,
    input wire logic       frame_fail,
    input wire logic       frame_crc_err,
    input wire logic [1:0] frame_rolloff,
    input wire logic       hdr_start,
    input wire logic       hdr_extended,
    input wire logic       hdr_derotate,
    input wire logic       hdr_short,
    input wire logic       skip_pulse,
    input wire logic       ro_small
);
    logic track_q;
    wire  code_ext  = hdr_code[CODE_EXT_BIT];
    wire  code_size = hdr_code[CODE_SIZE_BIT];
    wire  code_vl   = (hdr_code == CODE_VL_SET1) || (hdr_code == CODE_VL_SET2);
    wire  good_low  = frame_done & track_q & locked & ~frame_fail & ~frame_crc_err & (frame_rolloff == ROLLOFF_LOW);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A started frame waits for its outcome until the next frame_done.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            track_q <= 1'b0;
        else if (hdr_start)
            track_q <= 1'b1;
        else if (frame_done)
            track_q <= 1'b0;
    end
    pready_setup_a : assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_access_a : assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    slverr_ready_a : assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ext_class_a : assert property (hdr_valid |=> hdr_extended == $past(code_ext))
        else $error("extended flag wrong");
    derotate_ext_a : assert property (hdr_valid |=> hdr_derotate == $past(code_ext))
        else $error("derotate differs from extended");
    size_bit_a : assert property (hdr_valid |=> hdr_short == (!$past(code_ext) && $past(code_size)))
        else $error("short flag wrong");
    vl_skip_a : assert property (hdr_valid && code_vl |=> skip_pulse && !hdr_start)
        else $error("skip code not skipped");
    start_cause_a : assert property ((hdr_start || skip_pulse) |-> $past(hdr_valid))
        else $error("start without header");
    first_low_a : assert property (good_low |=> ro_small)
        else $error("first low roll-off missed");
    class_hold_a : assert property (!hdr_valid |=> $stable(hdr_extended))
        else $error("class level moved without header");
endmodule

bind pmrt_tracker pmrt_tracker_checker pmrt_tracker_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .locked(locked), .hdr_valid(hdr_valid), .hdr_code(hdr_code),
    .frame_done(frame_done), .frame_fail(frame_fail), .frame_crc_err(frame_crc_err),
    .frame_rolloff(frame_rolloff), .hdr_start(hdr_start), .hdr_extended(hdr_extended),
    .hdr_derotate(hdr_derotate), .hdr_short(hdr_short), .skip_pulse(skip_pulse), .ro_small(ro_small)
);

// ===== dv/pmrt_tx_model.sv
// Transmitter-side model that emits headers and frame outcomes with per-key roll-off alternation.
`timescale 1ns/10ps
module pmrt_tx_model
    import pmrt_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       req,
    input  wire logic [7:0] code_in,
    input  wire logic [7:0] slice_in,
    input  wire logic [1:0] bad,
    input  wire logic       alt_en,
    output logic            hdr_valid,
    output logic [7:0]      hdr_code,
    output logic [7:0]      time_slice_number,
    output logic            frame_done,
    output logic            frame_fail,
    output logic            frame_crc_err,
    output logic [1:0]      frame_rolloff
);
    logic [1:0]      st;
    logic [7:0]      code_q;
    logic [1:0]      bad_q;
    logic [KEYS-1:0] alt_q;
    wire [KEY_W-1:0] key = code_q[7] ? {1'b1, code_q[6:1]} : {2'b00, code_q[6:2]};
    wire             vl  = (code_q == CODE_VL_SET1) || (code_q == CODE_VL_SET2);

    // Released lines show the inverse of their last value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st                <= 2'd0;
            code_q            <= 8'h00;
            bad_q             <= 2'b00;
            alt_q             <= '0;
            hdr_valid         <= 1'b0;
            hdr_code          <= 8'h00;
            time_slice_number <= 8'h00;
            frame_done        <= 1'b0;
            frame_fail        <= 1'b0;
            frame_crc_err     <= 1'b0;
            frame_rolloff     <= 2'b00;
        end
        else if (st == 2'd0 && req)
        begin
            code_q            <= code_in;
            bad_q             <= bad;
            hdr_valid         <= 1'b1;
            hdr_code          <= code_in;
            time_slice_number <= slice_in;
            st                <= 2'd1;
        end
        else if (st == 2'd1)
        begin
            hdr_valid         <= 1'b0;
            hdr_code          <= ~code_q;
            time_slice_number <= ~time_slice_number;
            st                <= 2'd2;
        end
        else if (st == 2'd2)
        begin
            frame_done    <= !vl;
            frame_fail    <= bad_q[0];
            frame_crc_err <= bad_q[1];
            frame_rolloff <= (alt_en && alt_q[key]) ? ROLLOFF_LOW : 2'b00;
            alt_q[key]    <= alt_q[key] ^ (alt_en && !vl);
            st            <= 2'd3;
        end
        else if (st == 2'd3)
        begin
            frame_done    <= 1'b0;
            frame_fail    <= ~frame_fail;
            frame_crc_err <= ~frame_crc_err;
            frame_rolloff <= ~frame_rolloff;
            st            <= 2'd0;
        end
    end
endmodule

// ===== dv/tb.sv
// Self-checking bench of the header classifier and roll-off tracker.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb;
    import pmrt_pkg::*;
    typedef struct {logic [7:0] code; logic ext; logic shrt; logic skip; logic start;} pmrt_row_s;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, locked = 0, acq_start = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd_data;
    logic              pready, pslverr, hdr_valid, frame_done, frame_fail, frame_crc_err, rd_err;
    logic              vl_sync_det = 0, tx_req = 0, tx_alt = 0;
    logic [3:0]        vl_sync_modcod = 4'h0;
    logic [7:0]        hdr_code, slice, tx_code = 8'h00, tx_slice = 8'h00;
    logic [1:0]        frame_rolloff, tx_bad = 2'b00;
    logic              hdr_start, hdr_extended, hdr_derotate, hdr_short, skip_pulse, ro_small, irq;
    logic [CNT_W-1:0]  skip_len, o_len;
    logic              o_ext, o_rot, o_short, o_skip;
    int                num_errors = 0, n_checks = 0;
    pmrt_row_s rows [8] = '{'{8'h00, 0, 0, 0, 1}, '{8'h02, 0, 1, 0, 1}, '{8'h7f, 0, 1, 0, 1}, '{8'h80, 1, 0, 0, 1},
                            '{8'h82, 1, 0, 0, 1}, '{8'h81, 1, 0, 1, 0}, '{8'h83, 1, 0, 1, 0}, '{8'hff, 1, 0, 0, 1}};

    pmrt_tracker pmrt_tracker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .locked(locked),
        .acq_start(acq_start), .hdr_valid(hdr_valid), .hdr_code(hdr_code), .time_slice_number(slice),
        .frame_done(frame_done), .frame_fail(frame_fail), .frame_crc_err(frame_crc_err),
        .frame_rolloff(frame_rolloff), .vl_sync_det(vl_sync_det), .vl_sync_modcod(vl_sync_modcod),
        .hdr_start(hdr_start), .hdr_extended(hdr_extended), .hdr_derotate(hdr_derotate), .hdr_short(hdr_short),
        .skip_pulse(skip_pulse), .skip_len(skip_len), .ro_small(ro_small), .irq(irq));
    pmrt_tx_model pmrt_tx_model_i (.pclk(pclk), .presetn(presetn), .req(tx_req), .code_in(tx_code),
        .slice_in(tx_slice), .bad(tx_bad), .alt_en(tx_alt), .hdr_valid(hdr_valid), .hdr_code(hdr_code),
        .time_slice_number(slice), .frame_done(frame_done), .frame_fail(frame_fail),
        .frame_crc_err(frame_crc_err), .frame_rolloff(frame_rolloff));

    always #5 pclk = ~pclk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        `CHK("prdata", e, rd_data)
    endtask

    // One header, then its outcome two cycles later; class outputs are caught in their cycle.
    task automatic send(input logic [7:0] c, input logic [7:0] t, input logic [1:0] b, input logic a, input logic es);
        @(posedge pclk);
        tx_req  <= 1'b1;
        tx_code <= c;
        tx_slice <= t;
        tx_bad  <= b;
        tx_alt  <= a;
        @(posedge pclk);
        tx_req <= 1'b0;
        @(posedge pclk);
        #1;
        o_ext   = hdr_extended;
        o_rot   = hdr_derotate;
        o_short = hdr_short;
        o_skip  = skip_pulse;
        o_len   = skip_len;
        `CHK("hdr_start", es, hdr_start)
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic pulse_in(input logic sync);
        @(posedge pclk);
        vl_sync_det    <= sync;
        acq_start      <= !sync;
        vl_sync_modcod <= 4'h5;
        @(posedge pclk);
        vl_sync_det <= 1'b0;
        acq_start   <= 1'b0;
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("ro_small", 1'b0, ro_small)
        rd(OFF_THR_SMALL, 32'h10);
        rd(OFF_THR_WIDE, 32'h10);
        apb(1'b0, 8'h40, '0);
        `CHK("pslverr", 1'b1, rd_err)
        `CHK("prdata", 32'h0, rd_data)
        $display("test reset done");
        apb(1'b1, OFF_VL_LEN1, 32'h0123);
        apb(1'b1, OFF_VL_LEN2, 32'h0456);
        apb(1'b1, OFF_IRQ_MASK, 32'h6);
        foreach (rows[i])
        begin
            send(rows[i].code, 8'h00, 2'b00, 1'b1, rows[i].start);
            `CHK("hdr_extended", rows[i].ext, o_ext)
            `CHK("hdr_derotate", rows[i].ext, o_rot)
            `CHK("hdr_short", rows[i].shrt, o_short)
            `CHK("skip_pulse", rows[i].skip, o_skip)
            if (rows[i].skip)
                `CHK("skip_len", (rows[i].code == CODE_VL_SET1) ? 16'h0123 : 16'h0456, o_len)
        end
        `CHK("irq", 1'b1, irq)
        pulse_in(1'b1);
        rd(OFF_IRQ_STAT, 32'h6);
        apb(1'b1, OFF_CTRL, 32'h2);
        rd(OFF_SMALL_CNT, 32'h0);
        rd(OFF_WIDE_CNT, 32'h0);
        `CHK("irq", 1'b0, irq)
        $display("test classes done");
        apb(1'b1, OFF_THR_SMALL, 32'h2);
        repeat (2) send(8'h0c, 8'h00, 2'b00, 1'b1, 1'b1);
        `CHK("ro_small", 1'b0, ro_small)
        send(8'h0c, 8'h00, 2'b00, 1'b1, 1'b1);
        `CHK("ro_small", 1'b1, ro_small)
        rd(OFF_SMALL_CNT, 32'h2);
        `CHK("irq", 1'b0, irq)
        pulse_in(1'b0);
        rd(OFF_SMALL_CNT, 32'h0);
        $display("test threshold done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        locked  <= 1'b1;
        send(8'h04, 8'h00, 2'b00, 1'b1, 1'b1);
        `CHK("ro_small", 1'b0, ro_small)
        send(8'h04, 8'h00, 2'b00, 1'b1, 1'b1);
        `CHK("ro_small", 1'b1, ro_small)
        repeat (2) send(8'h08, 8'h00, 2'b00, 1'b0, 1'b1);
        send(8'h08, 8'h00, 2'b01, 1'b0, 1'b1);
        send(8'h08, 8'h00, 2'b10, 1'b0, 1'b1);
        send(8'h08, 8'h00, 2'b00, 1'b0, 1'b1);
        rd(OFF_WIDE_CNT, 32'h1);
        rd(OFF_SMALL_CNT, 32'h1);
        $display("test rolloff done");
        apb(1'b1, OFF_SUB_SLICE, 32'h5);
        apb(1'b1, OFF_CTRL, 32'h1);
        send(8'h10, 8'h05, 2'b00, 1'b1, 1'b1);
        send(8'h10, 8'h06, 2'b00, 1'b1, 1'b0);
        $display("test slices done");
        end_of_test();
    end
endmodule
